// >>> src/serh_pkg.sv
/*
 Shared constants and types of the serial EEPROM read and hold path.
 Assumes a byte-wide serial frame: opcode, 24-bit address, data bytes.
*/
package serh_pkg;
   // Widths
   localparam int ADDR_W   = 24;
   localparam int ARRAY_AW = 18;
   localparam int IDP_AW   = 8;
   localparam int CNT_W    = 6;

   // Frame bit counts
   localparam logic [5:0] LEN_OP_LAST   = 6'h07;
   localparam logic [5:0] LEN_CMD       = 6'h08;
   localparam logic [5:0] LEN_ARG_LAST  = 6'h0f;
   localparam logic [5:0] LEN_STATUS_WRITE_COMMAND      = 6'h10;
   localparam logic [5:0] LEN_ADDR_LAST = 6'h1f;
   localparam logic [5:0] LEN_DATA0     = 6'h20;
   localparam logic [5:0] LEN_WDAT_LAST = 6'h27;
   localparam logic [5:0] LEN_BYTE_WR   = 6'h28;

   // Status register bit positions
   localparam int ST_WPEN = 7;
   localparam int ST_IPL  = 6;
   localparam int ST_TWC  = 5;
   localparam int ST_LIP  = 4;
   localparam int ST_BP1  = 3;
   localparam int ST_BP0  = 2;
   localparam logic [7:0] STATUS_RST = 8'h00;

   // Default opcode encodings
   localparam logic [7:0] OP_STATUS_WRITE_COMMAND_DEF  = 8'h01;
   localparam logic [7:0] OP_WRITE_DEF = 8'h02;
   localparam logic [7:0] OP_READ_DEF  = 8'h03;
   localparam logic [7:0] OP_WRDI_DEF  = 8'h04;
   localparam logic [7:0] OP_STRD_DEF  = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE_COMMAND_DEF  = 8'h06;

   // Timing
   localparam int CLK_PERIOD_NS    = 8;
   localparam int WRITE_TIME_NS    = 5000000;
   localparam int WRITE_CYCLES_DEF = WRITE_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      LNK_CMD, LNK_ADDR, LNK_RDATA, LNK_STAT, LNK_WDATA, LNK_ARG, LNK_DEAD
   } serh_lnk_t;

   typedef enum logic {CTL_IDLE, CTL_PROG} serh_ctl_t;
endpackage : serh_pkg

// >>> src/serh_sync.sv
/*
 Two flip-flop level synchroniser, W bits wide.
 Assumes each bit is a slow level; bits are not coherent as a word.
*/
`timescale 1ns/1ns
`default_nettype none
module serh_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         en,
   // Data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else if (en)
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : serh_sync
`default_nettype wire

// >>> src/serh_store.sv
/*
 Main array and identification page storage.
 Write port on the system clock; asynchronous read port for the link side.
 Assumes reads and writes never hit the same word at once.
*/
`timescale 1ns/1ns
`default_nettype none
module serh_store #(
   parameter int AW = 18,
   parameter int IW = 8
) (
   // Write port
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic          wr_id,
   input  wire logic [AW-1:0] wa,
   input  wire logic [7:0]    wd,
   // Read port
   input  wire logic          rd_id,
   input  wire logic [AW-1:0] ra,
   output logic      [7:0]    rd_data
);
   logic [7:0] arr_mem [0:(1<<AW)-1];
   logic [7:0] idp_mem [0:(1<<IW)-1];

   // Page reads use only the low byte index
   assign rd_data = rd_id ? idp_mem[ra[IW-1:0]] : arr_mem[ra];

   always_ff @(posedge clk)
   begin
      if (we && wr_id)
         idp_mem[wa[IW-1:0]] <= wd;
      else if (we)
         arr_mem[wa] <= wd;
   end
endmodule : serh_store
`default_nettype wire

// >>> src/serh_top.sv
/*
 Serial EEPROM read, status and hold path with session control.
 Link logic runs on the serial clock; self-timed write and status live
 on clk. Assumes the host keeps the serial clock still while cs_b is high
 and that the frame registers are stable by the time cs_b rises.
*/
`timescale 1ns/1ns
`default_nettype none
// Function
// - Read opcode then full 24-bit address captured
// - Data shifts out right after last address bit
// - Pointer increments, next byte follows
// - Pointer wraps from top to bottom address
// - Raising select ends read, output released
// - Page reads index low eight address bits
// - Status byte shifts out after opcode
// - Status read answered even while programming
// - Hold tristates output, ignores input, keeps state
// - Reset gives write-disabled, idle device
// - Completed writes clear write-enable latch
// - Write cycle starts on select rise, exact length
// - Array access ignored during programming
// - Unknown opcode ignored, output stays released
// - Page-select bit clears after use
// - Ready bit high while programming
// - Only status read accepted while programming
// - Array uses low 18 address bits
module serh_top
   import serh_pkg::*;
#(
   parameter logic [7:0] OP_READ      = OP_READ_DEF,
   parameter logic [7:0] OP_STRD      = OP_STRD_DEF,
   parameter logic [7:0] OP_WRITE_ENABLE_COMMAND      = OP_WRITE_ENABLE_COMMAND_DEF,
   parameter logic [7:0] OP_WRDI      = OP_WRDI_DEF,
   parameter logic [7:0] OP_WRITE     = OP_WRITE_DEF,
   parameter logic [7:0] OP_STATUS_WRITE_COMMAND      = OP_STATUS_WRITE_COMMAND_DEF,
   parameter int         WRITE_CYCLES = WRITE_CYCLES_DEF
) (
   // System clock
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic ce,
   // Serial link
   input  wire logic sck,
   input  wire logic cs_b,
   input  wire logic si,
   input  wire logic hold_b,
   output logic      so_o,
   output logic      so_oe
);
   localparam int TW = $clog2(WRITE_CYCLES + 1);

   // Link side state
   serh_lnk_t               st_q;
   serh_lnk_t               st_d;
   serh_lnk_t               cur_st;
   logic                    fresh_q;
   logic [CNT_W-1:0]        cnt_q;
   logic [CNT_W-1:0]        cur_cnt;
   logic [CNT_W-1:0]        cnt_d;
   logic [2:0]              ph_q;
   logic [2:0]              ph_d;
   logic [7:0]              sh_q;
   logic [7:0]              in_byte;
   logic [7:0]              op_q;
   logic [ADDR_W-1:0]       addr_q;
   logic [7:0]              wdat_q;
   logic                    wdat_take;
   logic                    tog_q;
   logic                    link_rst_b;
   logic [7:0]              so_sh_q;
   logic [7:0]              so_sh_d;
   logic                    drive_q;
   logic [ARRAY_AW-1:0]     ptr_q;
   logic [ARRAY_AW-1:0]     rd_ptr;
   logic                    out_st;
   logic                    load;
   logic [7:0]              rd_data;
   logic [7:0]              stat_s;
   logic                    busy_s;
   logic                    ipl_s;
   logic                    is_arg;

   // System side state
   serh_ctl_t               ctl_q;
   logic                    cs_s;
   logic                    tog_s;
   logic                    cs_d_q;
   logic                    seen_q;
   logic                    frame_done;
   logic                    busy;
   logic                    go_cmd;
   logic                    do_write_enable_command;
   logic                    do_wrdi;
   logic                    do_status_write_command;
   logic                    do_write;
   logic                    do_rd_id;
   logic                    prog_end;
   logic [7:0]              sreg_q;
   logic [7:0]              sreg_d;
   logic [7:0]              status_write_command_val;
   logic                    wel_q;
   logic [TW-1:0]           tmr_q;
   logic [ARRAY_AW-1:0]     wa_q;
   logic [7:0]              wd_q;
   logic                    wid_q;
   logic                    warr_q;
   logic [7:0]              stat_pub;

   // Select high clears the frame tracking
   assign link_rst_b = rst_b & ~cs_b;

   // Frame decoding on the serial clock
   assign cur_st  = fresh_q ? LNK_CMD : st_q;
   assign cur_cnt = fresh_q ? '0 : cnt_q;
   assign in_byte = {sh_q[6:0], si};
   assign cnt_d   = (cur_cnt == LEN_BYTE_WR) ? cur_cnt : cur_cnt + 6'h01;
   assign ph_d    = fresh_q ? 3'h1 : ph_q + 3'h1;
   assign busy_s  = stat_s[0];
   assign ipl_s   = stat_s[ST_IPL];
   assign is_arg  = (in_byte == OP_WRITE_ENABLE_COMMAND) || (in_byte == OP_WRDI) || (in_byte == OP_STATUS_WRITE_COMMAND);
   assign wdat_take = ((cur_st == LNK_ARG) && (cur_cnt == LEN_ARG_LAST)) ||
                      ((cur_st == LNK_WDATA) && (cur_cnt == LEN_WDAT_LAST));

   always_comb
   begin
      st_d = cur_st;
      case (cur_st)
         LNK_CMD:
         begin
            if (cur_cnt == LEN_OP_LAST)
            begin
               if (in_byte == OP_STRD)
                  st_d = LNK_STAT;
               else if (busy_s)
                  st_d = LNK_DEAD;
               else if ((in_byte == OP_READ) || (in_byte == OP_WRITE))
                  st_d = LNK_ADDR;
               else if (is_arg)
                  st_d = LNK_ARG;
               else
                  st_d = LNK_DEAD;
            end
         end
         LNK_ADDR:
         begin
            if (cur_cnt == LEN_ADDR_LAST)
               st_d = (op_q == OP_READ) ? LNK_RDATA : LNK_WDATA;
         end
         default:
         begin
            st_d = cur_st;
         end
      endcase
   end

   // Marks the first rising edge of each selection
   always_ff @(posedge sck or negedge link_rst_b)
   begin
      if (!link_rst_b)
         fresh_q <= 1'b1;
      else if (hold_b)
         fresh_q <= 1'b0;
   end

   // Input side, frozen while held
   always_ff @(posedge sck or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q  <= LNK_CMD;
         cnt_q <= '0;
         ph_q  <= '0;
         sh_q  <= '0;
         tog_q <= 1'b0;
      end
      else if (hold_b)
      begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         ph_q  <= ph_d;
         sh_q  <= in_byte;
         tog_q <= tog_q ^ fresh_q;
      end
   end

   // Captured opcode, address and argument byte
   always_ff @(posedge sck or negedge rst_b)
   begin
      if (!rst_b)
      begin
         op_q   <= '0;
         addr_q <= '0;
         wdat_q <= '0;
      end
      else if (hold_b)
      begin
         if (cur_cnt == LEN_OP_LAST)
            op_q <= in_byte;
         if (cur_st == LNK_ADDR)
            addr_q <= {addr_q[ADDR_W-2:0], si};
         if (wdat_take)
            wdat_q <= in_byte;
      end
   end

   // Output side on the falling edge
   assign out_st  = (st_q == LNK_RDATA) || (st_q == LNK_STAT);
   assign load    = out_st && (ph_q == 3'h0);
   // Low 18 bits only, upper address bits ignored
   assign rd_ptr  = (cnt_q == LEN_DATA0) ? addr_q[ARRAY_AW-1:0] : ptr_q;
   assign so_sh_d = !load ? {so_sh_q[6:0], 1'b0} :
                    (st_q == LNK_STAT) ? stat_s : rd_data;

   always_ff @(negedge sck or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         so_sh_q <= '0;
         drive_q <= 1'b0;
         ptr_q   <= '0;
      end
      else if (hold_b && !fresh_q)
      begin
         so_sh_q <= so_sh_d;
         drive_q <= drive_q | load;
         if (load && (st_q == LNK_RDATA))
            ptr_q <= rd_ptr + 18'h0_0001;
      end
   end

   // Output released outside selection, on hold and for dead frames
   assign so_o  = so_sh_q[7];
   assign so_oe = ~cs_b & hold_b & drive_q;

   serh_store #(
      .AW (ARRAY_AW),
      .IW (IDP_AW)
   ) u_store (
      .clk     (clk),
      .we      (prog_end && warr_q),
      .wr_id   (wid_q),
      .wa      (wa_q),
      .wd      (wd_q),
      .rd_id   (ipl_s),
      .ra      (rd_ptr),
      .rd_data (rd_data)
   );

   // Status into the serial clock domain
   serh_sync #(
      .W (8)
   ) u_stat_sync (
      .clk   (sck),
      .rst_b (rst_b),
      .en    (1'b1),
      .d     (stat_pub),
      .q     (stat_s)
   );

   // Select and frame toggle into the system domain
   serh_sync #(
      .W (2)
   ) u_cs_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .en    (ce),
      .d     ({tog_q, cs_b}),
      .q     ({tog_s, cs_s})
   );

   // Frame end decode on select rise
   assign busy       = (ctl_q == CTL_PROG);
   assign frame_done = cs_s & ~cs_d_q & (tog_s != seen_q);
   assign go_cmd     = frame_done & ~busy;
   assign do_write_enable_command    = go_cmd && (op_q == OP_WRITE_ENABLE_COMMAND) && (cnt_q == LEN_CMD);
   assign do_wrdi    = go_cmd && (op_q == OP_WRDI) && (cnt_q == LEN_CMD);
   assign do_status_write_command    = go_cmd && (op_q == OP_STATUS_WRITE_COMMAND) && (cnt_q == LEN_STATUS_WRITE_COMMAND) && wel_q;
   assign do_write   = go_cmd && (op_q == OP_WRITE) && (cnt_q == LEN_BYTE_WR) &&
                       (ph_q == 3'h0) && wel_q;
   assign do_rd_id   = go_cmd && (op_q == OP_READ) && (cnt_q == LEN_BYTE_WR) &&
                       sreg_q[ST_IPL];
   assign prog_end   = busy && (tmr_q == TW'(WRITE_CYCLES - 1));

   // Writable status fields; page-select and lock may not rise together
   assign status_write_command_val[ST_WPEN] = wdat_q[ST_WPEN];
   assign status_write_command_val[ST_TWC]  = wdat_q[ST_TWC];
   assign status_write_command_val[ST_BP1]  = wdat_q[ST_BP1];
   assign status_write_command_val[ST_BP0]  = wdat_q[ST_BP0];
   assign status_write_command_val[ST_IPL]  = (wdat_q[ST_IPL] & wdat_q[ST_LIP]) ? sreg_q[ST_IPL] : wdat_q[ST_IPL];
   assign status_write_command_val[ST_LIP]  = (wdat_q[ST_IPL] & wdat_q[ST_LIP]) ? sreg_q[ST_LIP] : wdat_q[ST_LIP];
   assign status_write_command_val[1:0]     = 2'h0;

   always_comb
   begin
      sreg_d = sreg_q;
      if (do_status_write_command)
         sreg_d = status_write_command_val;
      else if ((prog_end && warr_q && wid_q) || do_rd_id)
         sreg_d[ST_IPL] = 1'b0;
   end

   assign stat_pub = {sreg_q[7:2], wel_q, busy};

   // Frame tracking
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cs_d_q <= 1'b1;
         seen_q <= 1'b0;
      end
      else if (ce)
      begin
         cs_d_q <= cs_s;
         if (frame_done)
            seen_q <= tog_s;
      end
   end

   // Status register and write-enable latch
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sreg_q <= STATUS_RST;
         wel_q  <= 1'b0;
      end
      else if (ce)
      begin
         sreg_q <= sreg_d;
         if (do_write_enable_command)
            wel_q <= 1'b1;
         else if (do_wrdi || prog_end)
            wel_q <= 1'b0;
      end
   end

   // Self-timed write cycle
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctl_q <= CTL_IDLE;
         tmr_q <= '0;
      end
      else if (ce)
      begin
         case (ctl_q)
            CTL_IDLE:
            begin
               tmr_q <= '0;
               if (do_write || do_status_write_command)
                  ctl_q <= CTL_PROG;
            end
            CTL_PROG:
            begin
               tmr_q <= tmr_q + TW'(1);
               if (prog_end)
                  ctl_q <= CTL_IDLE;
            end
            default:
            begin
               ctl_q <= CTL_IDLE;
            end
         endcase
      end
   end

   // Write target held for the whole cycle
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wa_q   <= '0;
         wd_q   <= '0;
         wid_q  <= 1'b0;
         warr_q <= 1'b0;
      end
      else if (ce && (do_write || do_status_write_command))
      begin
         wa_q   <= addr_q[ARRAY_AW-1:0];
         wd_q   <= wdat_q;
         wid_q  <= sreg_q[ST_IPL];
         warr_q <= do_write;
      end
   end
endmodule : serh_top
`default_nettype wire

// >>> testbench/serh_properties.sv
/*
 Port checker of serh_top, bound to every instance.
 Assumes default opcodes and sck held low between frames.
*/
`timescale 1ns/1ns
`default_nettype none
module serh_properties
   import serh_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
   // System
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Link
   input wire logic sck,
   input wire logic cs_b,
   input wire logic si,
   input wire logic hold_b,
   input wire logic so_o,
   input wire logic so_oe
);
   logic [5:0] bits_q;
   logic [7:0] op_q;
   // Bit count and opcode of the frame
   always_ff @(posedge sck or posedge cs_b)
   begin
      if (cs_b)
      begin
         bits_q <= 6'h00;
         op_q   <= 8'h00;
      end
      else if (hold_b)
      begin
         bits_q <= (bits_q == 6'h3f) ? bits_q : bits_q + 6'h01;
         op_q   <= (bits_q < LEN_CMD) ? {op_q[6:0], si} : op_q;
      end
   end
   chk_cs_release: assert property (
      @(posedge clk) disable iff (!rst_b) cs_b |-> !so_oe)
      else $error("output enabled while deselected");
   chk_hold_release: assert property (
      @(posedge clk) disable iff (!rst_b) !hold_b |-> !so_oe)
      else $error("output enabled during hold");
   chk_hold_freeze: assert property (
      @(posedge clk) disable iff (!rst_b) !hold_b && !$past(hold_b) |-> $stable(so_o))
      else $error("output bit moved during hold");
   chk_reset_quiet: assert property (
      @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> !so_oe [*2])
      else $error("output enabled after reset");
   chk_early_quiet: assert property (
      @(negedge sck) disable iff (!rst_b || cs_b)
      bits_q <= LEN_CMD || (op_q != OP_STRD_DEF && bits_q <= 6'h20) |-> !so_oe)
      else $error("output enabled before address complete");
   chk_out_timing: assert property (
      @(negedge sck) disable iff (!rst_b || cs_b) $rose(so_oe) && $stable(hold_b)
      |-> (op_q == OP_STRD_DEF && bits_q == 6'h09) || (op_q == OP_READ_DEF && bits_q == 6'h21))
      else $error("output enabled at wrong bit");
   chk_status_answer: assert property (
      @(negedge sck) disable iff (!rst_b || cs_b)
      op_q == OP_STRD_DEF && bits_q >= 6'h09 && hold_b |-> so_oe)
      else $error("status read not answered");
   chk_status_repeat: assert property (
      @(posedge sck) disable iff (!rst_b || cs_b)
      op_q == OP_STRD_DEF && bits_q >= 6'h10 && hold_b |-> so_o == $past(so_o, 8))
      else $error("status byte not repeated");
   chk_unknown_quiet: assert property (
      @(negedge sck) disable iff (!rst_b || cs_b)
      bits_q >= LEN_CMD && op_q != OP_READ_DEF && op_q != OP_STRD_DEF |-> !so_oe)
      else $error("output enabled for silent opcode");
   cov_read: cover property (@(negedge sck) op_q == OP_READ_DEF && bits_q == 6'h29 && so_oe);
   cov_status: cover property (@(negedge sck) op_q == OP_STRD_DEF && bits_q == 6'h11 && so_oe);
   cov_hold: cover property (@(posedge clk) !hold_b && !cs_b);
endmodule : serh_properties
bind serh_top serh_properties #(.WRITE_CYCLES(WRITE_CYCLES)) serh_properties_inst (
   .clk(clk), .rst_b(rst_b), .ce(ce), .sck(sck), .cs_b(cs_b), .si(si),
   .hold_b(hold_b), .so_o(so_o), .so_oe(so_oe));
`default_nettype wire

// >>> testbench/serh_host.sv
/*
 Host model of the serial link: frames, bytes and hold pauses.
 Assumes its tasks are called one at a time by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module serh_host (
   // Link to the device
   output var  logic sck,
   output var  logic cs_b,
   output var  logic si,
   output var  logic hold_b,
   // Answer
   input  wire logic so_o,
   input  wire logic so_oe
);
   localparam int HALF_NS = 40;
   initial
   begin
      sck = 1'b0;
      cs_b = 1'b1;
      si = 1'b1;
      hold_b = 1'b1;
   end
   task automatic start;
      #(HALF_NS / 2);
      cs_b = 1'b0;
      #(HALF_NS / 2);
   endtask : start
   // One byte, MSB first, taken at sck rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic oe);
      oe = 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
         si = tx[i];
         #(HALF_NS) sck = 1'b1;
         rx[i] = so_oe ? so_o : ~so_o;
         oe = oe & so_oe;
         #(HALF_NS) sck = 1'b0;
      end
   endtask : xfer
   task automatic stop;
      #(HALF_NS / 2);
      cs_b = 1'b1;
      si = ~si;
      #(HALF_NS * 3);
   endtask : stop
   // Pause while selected; sck and si keep moving
   task automatic pause(input int n, output logic oe);
      #(HALF_NS / 2);
      hold_b = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         si = ~si;
         #(HALF_NS) sck = 1'b1;
         #(HALF_NS) sck = 1'b0;
      end
      #(HALF_NS / 2);
      oe = so_oe;
      hold_b = 1'b1;
      #(HALF_NS / 2);
   endtask : pause
endmodule : serh_host
`default_nettype wire

// >>> testbench/test_serial_eeprom_read_hold_path.sv
/*
 Self-checking bench of serh_top driven by the host model.
 Assumes a short write cycle and default opcodes.
*/
`timescale 1ns/1ns
`default_nettype none
module test_serial_eeprom_read_hold_path;
   import serh_pkg::*;
   localparam int WCYC = 1000;
   logic       clk;
   logic       rst_b;
   logic       ce;
   wire logic  sck, cs_b, si, hold_b, so_o, so_oe;
   int         mismatches;
   int         tests_run;
   logic [7:0] rx;
   logic       oe;
   always #4 clk = ~clk;
   serh_top #(.WRITE_CYCLES(WCYC)) serh_top_inst (.clk(clk), .rst_b(rst_b), .ce(ce),
      .sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b), .so_o(so_o), .so_oe(so_oe));
   serh_host serh_host_inst (.sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b),
      .so_o(so_o), .so_oe(so_oe));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic op_addr(input logic [7:0] op, input logic [23:0] a, input int n);
      serh_host_inst.start();
      serh_host_inst.xfer(op, rx, oe);
      for (int i = 2; i >= 3 - n; i--)
         serh_host_inst.xfer(a[8*i +: 8], rx, oe);
   endtask : op_addr
   task automatic status(output logic [7:0] st);
      op_addr(OP_STRD_DEF, 24'h00_0000, 0);
      serh_host_inst.xfer(8'h00, st, oe);
      check({7'h00, oe}, 8'h01);
      serh_host_inst.stop();
   endtask : status
   task automatic t_power_up;
      op_addr(OP_STRD_DEF, 24'h00_0000, 3);
      check({7'h00, oe}, 8'h01);
      check(rx, STATUS_RST);
      serh_host_inst.stop();
      $display("power-up test done");
   endtask : t_power_up
   task automatic t_write(input logic [23:0] a, input logic [7:0] d, input logic [7:0] s);
      logic [7:0] st;
      op_addr(OP_WRITE_ENABLE_COMMAND_DEF, a, 0);
      serh_host_inst.stop();
      status(st);
      check(st, s | 8'h02);
      op_addr(OP_WRITE_DEF, a, 3);
      serh_host_inst.xfer(d, rx, oe);
      serh_host_inst.stop();
      status(st);
      check(st & 8'h01, 8'h01);
      op_addr(OP_READ_DEF, a, 3);
      serh_host_inst.xfer(8'h00, rx, oe);
      check({7'h00, oe}, 8'h00);
      serh_host_inst.stop();
      wait_ready(st);
      check(st, 8'h00);
      $display("write test done");
   endtask : t_write
   task automatic wait_ready(output logic [7:0] st);
      st = 8'h01;
      for (int n = 0; n < 20 && st[0] !== 1'b0; n++)
         status(st);
      if (st[0] !== 1'b0)
      begin
         mismatches++;
         print_verdict();
      end
   endtask : wait_ready
   task automatic set_ipl;
      logic [7:0] st;
      op_addr(OP_WRITE_ENABLE_COMMAND_DEF, 24'h00_0000, 0);
      serh_host_inst.stop();
      op_addr(OP_STATUS_WRITE_COMMAND_DEF, 24'h40_0000, 1);
      serh_host_inst.stop();
      wait_ready(st);
      check(st, 8'h40);
   endtask : set_ipl
   task automatic t_read_hold;
      op_addr(OP_READ_DEF, 24'hC3_FFFF, 3);
      serh_host_inst.xfer(8'h00, rx, oe);
      check(rx, 8'hA5);
      check({7'h00, oe}, 8'h01);
      serh_host_inst.pause(12, oe);
      check({7'h00, oe}, 8'h00);
      serh_host_inst.xfer(8'h00, rx, oe);
      check(rx, 8'h5A);
      serh_host_inst.xfer(8'h00, rx, oe);
      check(rx, 8'h3C);
      serh_host_inst.stop();
      check({7'h00, so_oe}, 8'h00);
      $display("read and hold test done");
   endtask : t_read_hold
   task automatic t_unknown;
      op_addr(8'hFF, 24'h00_0000, 3);
      serh_host_inst.xfer(8'h00, rx, oe);
      check({7'h00, oe}, 8'h00);
      serh_host_inst.stop();
      $display("unknown opcode test done");
   endtask : t_unknown
   task automatic t_id_page;
      logic [7:0] st;
      op_addr(OP_WRITE_ENABLE_COMMAND_DEF, 24'h00_0000, 0);
      serh_host_inst.stop();
      op_addr(OP_WRDI_DEF, 24'h00_0000, 0);
      serh_host_inst.stop();
      op_addr(OP_STATUS_WRITE_COMMAND_DEF, 24'h40_0000, 1);
      serh_host_inst.stop();
      status(st);
      check(st, 8'h00);
      set_ipl();
      t_write(24'hAB_CD07, 8'hC7, 8'h40);
      set_ipl();
      op_addr(OP_READ_DEF, 24'h5A_A507, 3);
      serh_host_inst.xfer(8'h00, rx, oe);
      check(rx, 8'hC7);
      serh_host_inst.stop();
      status(st);
      check(st, 8'h00);
      $display("identification page test done");
   endtask : t_id_page
   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      ce = 1'b1;
      mismatches = 0;
      tests_run = 0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      #3;
      t_power_up();
      t_write(24'hFF_FFFF, 8'hA5, 8'h00);
      t_write(24'h00_0000, 8'h5A, 8'h00);
      t_write(24'h04_0001, 8'h3C, 8'h00);
      t_read_hold();
      t_unknown();
      t_id_page();
      print_verdict();
   end
endmodule : test_serial_eeprom_read_hold_path
`default_nettype wire
